// [design/hpe_pkg.sv]
// shared constants and types for the host port error flag bank
package hpe_pkg;

  // register offsets and reset values
  localparam logic [7:0] FIRST_STATUS_OFS = 8'h08;
  localparam logic [7:0] SECOND_STATUS_OFS = 8'h09;
  localparam logic [31:0] FIRST_STATUS_RESET = 32'h00000040;
  localparam logic [31:0] SECOND_STATUS_RESET = 32'h00000000;

  // first status flag positions
  localparam int TX_PROTOCOL_ERROR_BIT = 0;
  localparam int HOST_TX_OVERFLOW_BIT = 1;
  localparam int HOST_TX_UNDERRUN_BIT = 2;
  localparam int RX_BUFFER_OVERFLOW_BIT = 3;
  localparam int FRAMING_LOSS_BIT = 4;
  localparam int RESET_COMPLETE_BIT = 6;
  localparam int CONTROL_PROTECTION_ERROR_BIT = 12;

  // second status flag positions
  localparam int PORT_TWO_STAMP_SLOT_C_BIT = 22;
  localparam int PORT_TWO_SHORT_GAP_BIT = 23;
  localparam int PORT_TWO_TX_CRC_BIT = 24;

  // implemented flag masks
  localparam logic [31:0] FIRST_STATUS_MASK = 32'h0000105F;
  localparam logic [31:0] SECOND_STATUS_MASK = 32'h01C00000;

  // host transmit fifo
  localparam int TX_FIFO_BYTES = 4096;
  localparam int TX_FREE_W = 13;
  localparam logic [15:0] GENERIC_WR_BYTES = 16'h0004;

  // gap measurement
  localparam int GAP_W = 16;
  localparam logic [15:0] GAP_COUNT_MAX = 16'hFFFF;

  // link side events
  localparam int LINK_EVT_N = 2;

  // host transmit fifo write state
  typedef enum logic [1:0] {
    TXS_IDLE = 2'b00,
    TXS_LOAD = 2'b01,
    TXS_DISCARD = 2'b11
  } hpe_txs_t;

endpackage

// [design/hpe_evt_sync.sv]
// toggle crossing of link events and one level into the system clock
module hpe_evt_sync (
  // link side
  input wire logic lclk,
  input wire logic lrst_n,
  input wire logic [hpe_pkg::LINK_EVT_N-1:0] evt_in,
  input wire logic level_in,
  // system side
  input wire logic clk,
  input wire logic rst_n,
  output logic [hpe_pkg::LINK_EVT_N-1:0] evt_out,
  output logic level_out
);

  logic level_meta_reg;
  logic level_sync_reg;

  genvar i;
  generate
    for (i = 0; i < hpe_pkg::LINK_EVT_N; i++) begin : g_evt
      logic tog_reg;
      logic meta_reg;
      logic sync_reg;
      logic seen_reg;
      always_ff @(posedge lclk) begin
        if (!lrst_n) tog_reg <= 1'b0;
        else if (evt_in[i]) tog_reg <= ~tog_reg;
      end
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
          seen_reg <= 1'b0;
        end else begin
          meta_reg <= tog_reg;
          sync_reg <= meta_reg;
          seen_reg <= sync_reg;
        end
      end
      assign evt_out[i] = sync_reg ^ seen_reg;
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      level_meta_reg <= 1'b0;
      level_sync_reg <= 1'b0;
    end else begin
      level_meta_reg <= level_in;
      level_sync_reg <= level_meta_reg;
    end
  end

  assign level_out = level_sync_reg;

endmodule

// [design/hpe_chunk_check.sv]
// link clock checker for chunk headers, transaction length and frame size
module hpe_chunk_check (
  // link clock and reset
  input wire logic lclk,
  input wire logic rst_n_async,
  output logic lrst_n,
  // chunk decode
  input wire logic hdr_stb,
  input wire logic chunk_data_valid,
  input wire logic chunk_start_valid,
  input wire logic chunk_end_valid,
  input wire logic [7:0] xfer_bytes,
  input wire logic byte_stb,
  // generic mode frame writes
  input wire logic generic_mode_pin,
  input wire logic len_wr,
  input wire logic [15:0] len_val,
  input wire logic data_wr,
  // results
  output logic xfer_open,
  output logic [hpe_pkg::LINK_EVT_N-1:0] err_evt
);

  logic rst_meta_reg, rst_sync_reg;
  logic gen_meta_reg, gen_sync_reg;
  logic [7:0] left_reg;
  logic frame_open_reg;
  logic [15:0] owed_reg;

  // reset and mode synchronisers
  always_ff @(posedge lclk) begin
    rst_meta_reg <= rst_n_async;
    rst_sync_reg <= rst_meta_reg;
  end
  assign lrst_n = rst_sync_reg;

  always_ff @(posedge lclk) begin
    if (!lrst_n) begin
      gen_meta_reg <= 1'b0;
      gen_sync_reg <= 1'b0;
    end else begin
      gen_meta_reg <= generic_mode_pin;
      gen_sync_reg <= gen_meta_reg;
    end
  end

  // bytes still expected in this transaction
  always_ff @(posedge lclk) begin
    if (!lrst_n) left_reg <= 8'h00;
    else if (hdr_stb) left_reg <= xfer_bytes;
    else if (byte_stb && left_reg != 8'h00) left_reg <= left_reg - 8'h01;
  end
  assign xfer_open = (left_reg != 8'h00);

  // frame start and end tracking
  always_ff @(posedge lclk) begin
    if (!lrst_n) frame_open_reg <= 1'b0;
    else if (hdr_stb && chunk_end_valid) frame_open_reg <= 1'b0;
    else if (hdr_stb && chunk_start_valid) frame_open_reg <= 1'b1;
  end

  // bytes still owed for the announced frame size
  always_ff @(posedge lclk) begin
    if (!lrst_n) owed_reg <= 16'h0000;
    else if (len_wr) owed_reg <= len_val;
    else if (data_wr && owed_reg > hpe_pkg::GENERIC_WR_BYTES) owed_reg <= owed_reg - hpe_pkg::GENERIC_WR_BYTES;
    else if (data_wr) owed_reg <= 16'h0000;
  end

  assign err_evt[0] = hdr_stb && ((chunk_data_valid && !chunk_start_valid && !frame_open_reg)
                      || (chunk_start_valid && frame_open_reg));
  assign err_evt[1] = gen_sync_reg && len_wr && owed_reg != 16'h0000;

endmodule

// [design/hpe_status_top.sv]
// sticky error flags of the host port and port two status
//
// Behaviour
// - early chip select release sets framing loss
// - protection error also sets framing loss
// - receive buffer overflow sets bit 3
// - underrun flagged only in cut-through, aborts packet
// - overflow flags, discards frame until next start
// - transmit fifo holds at least 4 kB
// - data-valid without start-valid outside an open frame is protocol error
// - repeated start-valid is protocol error
// - new frame size while writes owed errors
// - port two transmit crc mismatch bit 24
// - short gap drops frame, sets bit 23
// - port two stamp slot c bit 22
// - second register at 0x09, resets zero
// - control write integrity failure sets bit 12
// - first register at 0x08, resets 0x40
module hpe_status_top (
  // system clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // link clock and chip select
  input wire logic SCLK,
  input wire logic CS_N,
  // link side chunk decode
  input wire logic LNK_HDR_STB,
  input wire logic LNK_DATA_VALID,
  input wire logic LNK_START_VALID,
  input wire logic LNK_END_VALID,
  input wire logic [7:0] LNK_XFER_BYTES,
  input wire logic LNK_BYTE_STB,
  input wire logic GENERIC_MODE,
  input wire logic LNK_LEN_WR,
  input wire logic [15:0] LNK_LEN,
  input wire logic LNK_DATA_WR,
  // control data protection
  input wire logic CTRL_PROT_FAIL,
  // register access
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output logic REG_RVALID,
  // host transmit fifo
  input wire logic TX_CUT_THROUGH,
  input wire logic TX_WR,
  input wire logic TX_SOF,
  input wire logic [hpe_pkg::TX_FREE_W-1:0] TX_FREE,
  output logic TX_WR_ACCEPT,
  input wire logic TX_SENDING,
  input wire logic TX_EMPTY,
  output logic TX_ABORT,
  // network receive buffer
  input wire logic RX_BUF_OVERFLOW,
  // port two
  input wire logic P2_TX_CRC_BAD,
  input wire logic P2_RX_ACTIVE,
  input wire logic [hpe_pkg::GAP_W-1:0] PORT_TWO_GAP_THRESHOLD,
  output logic P2_RX_DROP,
  input wire logic P2_STAMP_C
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic lrst_n;
  logic lnk_open;
  logic [hpe_pkg::LINK_EVT_N-1:0] lnk_err;
  logic [hpe_pkg::LINK_EVT_N-1:0] sys_err;
  logic sys_open;

  logic cs_meta_reg;
  logic cs_sync_reg;
  logic cs_prev_reg;
  logic cs_release;

  logic cut_meta_reg;
  logic cut_sync_reg;

  hpe_pkg::hpe_txs_t txs_reg;
  hpe_pkg::hpe_txs_t txs_next;
  logic tx_overflow;
  logic tx_accept_next;
  logic tx_underrun;
  logic abort_hold_reg;

  logic [hpe_pkg::GAP_W-1:0] gap_cnt_reg;
  logic rx_prev_reg;
  logic short_gap;

  logic [31:0] first_reg;
  logic [31:0] first_next;
  logic [31:0] first_set;
  logic [31:0] first_clr;
  logic [31:0] second_reg;
  logic [31:0] second_next;
  logic [31:0] second_set;
  logic [31:0] second_clr;

  ////////////////////////////////////////////////////////////////////////////
  // link clock domain

  hpe_chunk_check u_chunk (
    .lclk(SCLK),
    .rst_n_async(RST_N),
    .lrst_n(lrst_n),
    .hdr_stb(LNK_HDR_STB),
    .chunk_data_valid(LNK_DATA_VALID),
    .chunk_start_valid(LNK_START_VALID),
    .chunk_end_valid(LNK_END_VALID),
    .xfer_bytes(LNK_XFER_BYTES),
    .byte_stb(LNK_BYTE_STB),
    .generic_mode_pin(GENERIC_MODE),
    .len_wr(LNK_LEN_WR),
    .len_val(LNK_LEN),
    .data_wr(LNK_DATA_WR),
    .xfer_open(lnk_open),
    .err_evt(lnk_err)
  );

  hpe_evt_sync u_sync (
    .lclk(SCLK),
    .lrst_n(lrst_n),
    .evt_in(lnk_err),
    .level_in(lnk_open),
    .clk(CLK),
    .rst_n(RST_N),
    .evt_out(sys_err),
    .level_out(sys_open)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cs_meta_reg <= 1'b1;
      cs_sync_reg <= 1'b1;
      cs_prev_reg <= 1'b1;
    end else begin
      cs_meta_reg <= CS_N;
      cs_sync_reg <= cs_meta_reg;
      cs_prev_reg <= cs_sync_reg;
    end
  end

  // chip select released while bytes still expected
  assign cs_release = cs_sync_reg && !cs_prev_reg && sys_open;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cut_meta_reg <= 1'b0;
      cut_sync_reg <= 1'b0;
    end else begin
      cut_meta_reg <= TX_CUT_THROUGH;
      cut_sync_reg <= cut_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // host transmit fifo write side

  always_comb begin
    txs_next = txs_reg;
    tx_overflow = 1'b0;
    tx_accept_next = 1'b0;
    if (TX_WR) begin
      unique case (txs_reg)
        hpe_pkg::TXS_IDLE, hpe_pkg::TXS_LOAD: begin
          if (TX_FREE == '0) begin
            tx_overflow = 1'b1;
            txs_next = hpe_pkg::TXS_DISCARD;
          end else begin
            tx_accept_next = 1'b1;
            txs_next = hpe_pkg::TXS_LOAD;
          end
        end
        hpe_pkg::TXS_DISCARD: begin
          if (TX_SOF && TX_FREE != '0) begin
            tx_accept_next = 1'b1;
            txs_next = hpe_pkg::TXS_LOAD;
          end else if (TX_SOF) begin
            tx_overflow = 1'b1;
          end
        end
        default: begin
          txs_next = hpe_pkg::TXS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      txs_reg <= hpe_pkg::TXS_IDLE;
      TX_WR_ACCEPT <= 1'b0;
    end else begin
      txs_reg <= txs_next;
      TX_WR_ACCEPT <= tx_accept_next;
    end
  end

  // underrun only while cut-through, one abort per packet
  assign tx_underrun = cut_sync_reg && TX_SENDING && TX_EMPTY;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      abort_hold_reg <= 1'b0;
      TX_ABORT <= 1'b0;
    end else begin
      TX_ABORT <= tx_underrun && !abort_hold_reg;
      if (!TX_SENDING) abort_hold_reg <= 1'b0;
      else if (tx_underrun) abort_hold_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port two receive gap check

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      gap_cnt_reg <= hpe_pkg::GAP_COUNT_MAX;
      rx_prev_reg <= 1'b0;
    end else begin
      rx_prev_reg <= P2_RX_ACTIVE;
      if (P2_RX_ACTIVE) gap_cnt_reg <= '0;
      else if (gap_cnt_reg != hpe_pkg::GAP_COUNT_MAX) gap_cnt_reg <= gap_cnt_reg + 16'h0001;
    end
  end

  assign short_gap = P2_RX_ACTIVE && !rx_prev_reg && gap_cnt_reg < PORT_TWO_GAP_THRESHOLD;

  always_ff @(posedge CLK) begin
    if (!RST_N) P2_RX_DROP <= 1'b0;
    else if (short_gap) P2_RX_DROP <= 1'b1;
    else if (!P2_RX_ACTIVE) P2_RX_DROP <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // flag set and clear vectors

  always_comb begin
    first_set = 32'h00000000;
    first_set[hpe_pkg::FRAMING_LOSS_BIT] = cs_release || CTRL_PROT_FAIL;
    first_set[hpe_pkg::RX_BUFFER_OVERFLOW_BIT] = RX_BUF_OVERFLOW;
    first_set[hpe_pkg::HOST_TX_UNDERRUN_BIT] = tx_underrun;
    first_set[hpe_pkg::HOST_TX_OVERFLOW_BIT] = tx_overflow;
    first_set[hpe_pkg::TX_PROTOCOL_ERROR_BIT] = |sys_err;
    first_set[hpe_pkg::CONTROL_PROTECTION_ERROR_BIT] = CTRL_PROT_FAIL;
  end

  always_comb begin
    second_set = 32'h00000000;
    second_set[hpe_pkg::PORT_TWO_TX_CRC_BIT] = P2_TX_CRC_BAD;
    second_set[hpe_pkg::PORT_TWO_SHORT_GAP_BIT] = short_gap;
    second_set[hpe_pkg::PORT_TWO_STAMP_SLOT_C_BIT] = P2_STAMP_C;
  end

  // write one to clear
  assign first_clr = (REG_WR && REG_ADDR == hpe_pkg::FIRST_STATUS_OFS) ? REG_WDATA : 32'h00000000;
  assign second_clr = (REG_WR && REG_ADDR == hpe_pkg::SECOND_STATUS_OFS) ? REG_WDATA : 32'h00000000;

  // set wins over a clear in the same cycle
  assign first_next = ((first_reg & ~first_clr) | first_set) & hpe_pkg::FIRST_STATUS_MASK;
  assign second_next = ((second_reg & ~second_clr) | second_set) & hpe_pkg::SECOND_STATUS_MASK;

  ////////////////////////////////////////////////////////////////////////////
  // status registers

  // one sticky cell per bit of each register
  genvar b;
  generate
    for (b = 0; b < 32; b++) begin : g_flag
      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          first_reg[b] <= hpe_pkg::FIRST_STATUS_RESET[b];
          second_reg[b] <= hpe_pkg::SECOND_STATUS_RESET[b];
        end else begin
          first_reg[b] <= first_next[b];
          second_reg[b] <= second_next[b];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // register read port

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      REG_RDATA <= 32'h00000000;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      if (!REG_RD) REG_RDATA <= 32'h00000000;
      else if (REG_ADDR == hpe_pkg::FIRST_STATUS_OFS) REG_RDATA <= first_reg;
      else if (REG_ADDR == hpe_pkg::SECOND_STATUS_OFS) REG_RDATA <= second_reg;
      else REG_RDATA <= 32'h00000000;
    end
  end

endmodule

// [tb/hpe_host_model.sv]
// host side model: gated link clock, chip select and chunk decode
module hpe_host_model (
  // link outputs
  output logic SCLK,
  output logic CS_N,
  output logic LNK_HDR_STB,
  output logic LNK_DATA_VALID,
  output logic LNK_START_VALID,
  output logic LNK_END_VALID,
  output logic [7:0] LNK_XFER_BYTES,
  output logic LNK_BYTE_STB
);
  timeunit 1ns;
  timeprecision 100ps;
  logic run = 1'b1;
  initial begin
    {SCLK, CS_N, LNK_HDR_STB, LNK_BYTE_STB} = 4'h4;
    {LNK_DATA_VALID, LNK_START_VALID, LNK_END_VALID} = 3'h0;
    LNK_XFER_BYTES = 8'h00;
    #7;
    forever #40 if (run || SCLK) SCLK = ~SCLK;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    run = 1'b1;
    repeat (n) @(negedge SCLK);
  endtask
  task automatic idle;
    repeat (3) @(negedge SCLK);
    run = 1'b0;
  endtask
  // one chunk of n bytes, chip select released after sent bytes
  task automatic chunk(input logic dv, input logic sv, input logic ev, input logic [7:0] n, input int sent);
    run = 1'b1;
    @(negedge SCLK);
    CS_N = 1'b0;
    LNK_HDR_STB = 1'b1;
    {LNK_DATA_VALID, LNK_START_VALID, LNK_END_VALID} = {dv, sv, ev};
    LNK_XFER_BYTES = n;
    @(negedge SCLK);
    LNK_HDR_STB = 1'b0;
    {LNK_DATA_VALID, LNK_START_VALID, LNK_END_VALID} = ~{dv, sv, ev};
    LNK_XFER_BYTES = ~n;
    repeat (sent) begin
      LNK_BYTE_STB = 1'b1;
      @(negedge SCLK);
      LNK_BYTE_STB = 1'b0;
      @(negedge SCLK);
    end
    CS_N = 1'b1;
    idle();
  endtask
endmodule

// [tb/hpe_status_properties.sv]
// port assertions for the host port error flag bank
module hpe_status_properties (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // register access
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire logic REG_RVALID,
  // events and fifo
  input wire logic RX_BUF_OVERFLOW,
  input wire logic CTRL_PROT_FAIL,
  input wire logic P2_TX_CRC_BAD,
  input wire logic TX_WR,
  input wire logic [hpe_pkg::TX_FREE_W-1:0] TX_FREE,
  input wire logic TX_WR_ACCEPT,
  input wire logic TX_CUT_THROUGH,
  input wire logic TX_ABORT,
  input wire logic P2_RX_ACTIVE,
  input wire logic P2_RX_DROP
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  sequence s_rd1;
    REG_RD && REG_ADDR == 8'h08;
  endsequence
  sequence s_rd2;
    REG_RD && REG_ADDR == 8'h09;
  endsequence
  AST_RVALID: assert property (REG_RD |=> REG_RVALID) else $error("read not answered");
  AST_RDATA_IDLE: assert property (!REG_RVALID |-> REG_RDATA == 32'h00000000) else $error("data without read");
  AST_UNMAPPED: assert property (REG_RD && REG_ADDR != 8'h08 && REG_ADDR != 8'h09 |=> REG_RDATA == 32'h00000000)
    else $error("unmapped read not zero");
  AST_RSVD_SECOND: assert property (s_rd2 |=> (REG_RDATA & 32'hFE3FFFFF) == 32'h00000000)
    else $error("reserved bits set");
  AST_OVERFLOW_SEEN: assert property (RX_BUF_OVERFLOW ##1 !REG_WR ##1 s_rd1 |=> REG_RDATA[3])
    else $error("overflow flag late");
  AST_PROT_BOTH: assert property (CTRL_PROT_FAIL ##1 !REG_WR ##1 s_rd1 |=> REG_RDATA[12] && REG_RDATA[4])
    else $error("protection flags not paired");
  AST_CRC_SEEN: assert property (P2_TX_CRC_BAD ##1 !REG_WR ##1 s_rd2 |=> REG_RDATA[24])
    else $error("crc flag late");
  AST_FULL_REFUSED: assert property (TX_WR && TX_FREE == 13'h0000 |=> !TX_WR_ACCEPT) else $error("write to full");
  AST_NO_ABORT: assert property (!TX_CUT_THROUGH [*3] |=> !TX_ABORT) else $error("abort without cut-through");
  AST_DROP_HOLD: assert property (P2_RX_DROP && P2_RX_ACTIVE |=> P2_RX_DROP) else $error("drop released early");
endmodule
bind hpe_status_top hpe_status_properties hpe_status_properties_i (.CLK, .RST_N, .REG_ADDR, .REG_WR, .REG_RD, .REG_RDATA,
  .REG_RVALID, .RX_BUF_OVERFLOW, .CTRL_PROT_FAIL, .P2_TX_CRC_BAD, .TX_WR, .TX_FREE, .TX_WR_ACCEPT,
  .TX_CUT_THROUGH, .TX_ABORT, .P2_RX_ACTIVE, .P2_RX_DROP);

// [tb/tb_top.sv]
// self-checking bench for the host port error flag bank
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic SCLK, CS_N, LNK_HDR_STB, LNK_DATA_VALID, LNK_START_VALID, LNK_END_VALID, LNK_BYTE_STB;
  logic [7:0] LNK_XFER_BYTES;
  logic GENERIC_MODE = 1'b0, LNK_LEN_WR = 1'b0, LNK_DATA_WR = 1'b0, CTRL_PROT_FAIL = 1'b0;
  logic [15:0] LNK_LEN = 16'h0000;
  logic [7:0] REG_ADDR = 8'h00;
  logic REG_WR = 1'b0, REG_RD = 1'b0, REG_RVALID;
  logic [31:0] REG_WDATA = 32'h00000000, REG_RDATA;
  logic TX_CUT_THROUGH = 1'b0, TX_WR = 1'b0, TX_SOF = 1'b0, TX_SENDING = 1'b0, TX_EMPTY = 1'b0;
  logic [hpe_pkg::TX_FREE_W-1:0] TX_FREE = 13'h0064;
  logic TX_WR_ACCEPT, TX_ABORT, P2_RX_DROP;
  logic RX_BUF_OVERFLOW = 1'b0, P2_TX_CRC_BAD = 1'b0, P2_RX_ACTIVE = 1'b0, P2_STAMP_C = 1'b0;
  logic [hpe_pkg::GAP_W-1:0] PORT_TWO_GAP_THRESHOLD = 16'h000A;
  int err_count = 0;
  int total_checks = 0;
  always #2 CLK = ~CLK;
  hpe_host_model hpe_host_model_i (.SCLK, .CS_N, .LNK_HDR_STB, .LNK_DATA_VALID, .LNK_START_VALID, .LNK_END_VALID,
    .LNK_XFER_BYTES, .LNK_BYTE_STB);
  hpe_status_top hpe_status_top_i (.CLK, .RST_N, .SCLK, .CS_N, .LNK_HDR_STB, .LNK_DATA_VALID, .LNK_START_VALID,
    .LNK_END_VALID, .LNK_XFER_BYTES, .LNK_BYTE_STB, .GENERIC_MODE, .LNK_LEN_WR, .LNK_LEN, .LNK_DATA_WR,
    .CTRL_PROT_FAIL, .REG_ADDR, .REG_WR, .REG_WDATA, .REG_RD, .REG_RDATA, .REG_RVALID, .TX_CUT_THROUGH, .TX_WR,
    .TX_SOF, .TX_FREE, .TX_WR_ACCEPT, .TX_SENDING, .TX_EMPTY, .TX_ABORT, .RX_BUF_OVERFLOW, .P2_TX_CRC_BAD,
    .P2_RX_ACTIVE, .PORT_TWO_GAP_THRESHOLD, .P2_RX_DROP, .P2_STAMP_C);
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(negedge CLK);
    REG_RD = 1'b1;
    REG_ADDR = a;
    @(negedge CLK);
    REG_RD = 1'b0;
    chk("rvalid", 32'h00000001, {31'h00000000, REG_RVALID});
    chk("rdata", exp, REG_RDATA);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge CLK);
    REG_WR = 1'b1;
    REG_ADDR = a;
    REG_WDATA = d;
    @(negedge CLK);
    REG_WR = 1'b0;
  endtask
  task automatic clr;
    wr(8'h08, 32'hFFFFFFFF);
    wr(8'h09, 32'hFFFFFFFF);
  endtask
  task automatic ev(input logic [3:0] m);
    @(negedge CLK);
    {RX_BUF_OVERFLOW, P2_TX_CRC_BAD, P2_STAMP_C, CTRL_PROT_FAIL} = m;
    @(negedge CLK);
    {RX_BUF_OVERFLOW, P2_TX_CRC_BAD, P2_STAMP_C, CTRL_PROT_FAIL} = 4'h0;
  endtask
  task automatic txw(input logic sof, input logic [hpe_pkg::TX_FREE_W-1:0] free, input logic exp);
    @(negedge CLK);
    TX_WR = 1'b1;
    TX_SOF = sof;
    TX_FREE = free;
    @(negedge CLK);
    TX_WR = 1'b0;
    chk("accept", {31'h00000000, exp}, {31'h00000000, TX_WR_ACCEPT});
  endtask
  task automatic aborts(input int exp);
    int n;
    n = 0;
    repeat (12) begin
      @(negedge CLK);
      if (TX_ABORT === 1'b1) n++;
    end
    chk("aborts", exp, n);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(8'h08, 32'h00000040);
    rd(8'h09, 32'h00000000);
    rd(8'h0A, 32'h00000000);
    wr(8'h08, 32'h00000000);
    rd(8'h08, 32'h00000040);
    wr(8'h08, 32'h00000040);
    rd(8'h08, 32'h00000000);
    $display("test reset done");
  endtask
  task automatic t_events;
    ev(4'hF);
    rd(8'h08, 32'h00001018);
    rd(8'h09, 32'h01400000);
    @(negedge CLK);
    REG_WR = 1'b1;
    REG_ADDR = 8'h08;
    REG_WDATA = 32'h00001018;
    RX_BUF_OVERFLOW = 1'b1;
    @(negedge CLK);
    REG_WR = 1'b0;
    RX_BUF_OVERFLOW = 1'b0;
    rd(8'h08, 32'h00000008);
    clr();
    rd(8'h09, 32'h00000000);
    ev(4'h4);
    rd(8'h09, 32'h01000000);
    clr();
    $display("test events done");
  endtask
  task automatic t_fifo;
    txw(1'b1, 13'h0000, 1'b0);
    rd(8'h08, 32'h00000002);
    txw(1'b0, 13'h0064, 1'b0);
    txw(1'b1, 13'h0064, 1'b1);
    txw(1'b0, 13'h0064, 1'b1);
    clr();
    $display("test fifo done");
  endtask
  task automatic t_under;
    TX_SENDING = 1'b1;
    TX_EMPTY = 1'b1;
    aborts(0);
    rd(8'h08, 32'h00000000);
    TX_CUT_THROUGH = 1'b1;
    aborts(1);
    rd(8'h08, 32'h00000004);
    TX_SENDING = 1'b0;
    TX_CUT_THROUGH = 1'b0;
    clr();
    $display("test underrun done");
  endtask
  task automatic t_gap;
    @(negedge CLK);
    P2_RX_ACTIVE = 1'b1;
    @(negedge CLK);
    chk("drop", 32'h00000000, {31'h00000000, P2_RX_DROP});
    repeat (4) @(negedge CLK);
    P2_RX_ACTIVE = 1'b0;
    repeat (3) @(negedge CLK);
    P2_RX_ACTIVE = 1'b1;
    @(negedge CLK);
    chk("drop", 32'h00000001, {31'h00000000, P2_RX_DROP});
    @(negedge CLK);
    chk("drop", 32'h00000001, {31'h00000000, P2_RX_DROP});
    P2_RX_ACTIVE = 1'b0;
    repeat (3) @(negedge CLK);
    chk("drop", 32'h00000000, {31'h00000000, P2_RX_DROP});
    rd(8'h09, 32'h00800000);
    clr();
    $display("test gap done");
  endtask
  task automatic t_link;
    hpe_host_model_i.chunk(1'b1, 1'b0, 1'b0, 8'h04, 4);
    rd(8'h08, 32'h00000001);
    clr();
    hpe_host_model_i.chunk(1'b1, 1'b1, 1'b1, 8'h08, 3);
    rd(8'h08, 32'h00000010);
    clr();
    hpe_host_model_i.chunk(1'b1, 1'b1, 1'b0, 8'h04, 4);
    hpe_host_model_i.chunk(1'b1, 1'b1, 1'b0, 8'h04, 4);
    rd(8'h08, 32'h00000001);
    $display("test link done");
  endtask
  task automatic t_generic;
    clr();
    GENERIC_MODE = 1'b1;
    hpe_host_model_i.tick(3);
    LNK_LEN = 16'h0008;
    LNK_LEN_WR = 1'b1;
    hpe_host_model_i.tick(1);
    LNK_LEN_WR = 1'b0;
    LNK_DATA_WR = 1'b1;
    hpe_host_model_i.tick(1);
    LNK_DATA_WR = 1'b0;
    LNK_LEN = 16'h0004;
    LNK_LEN_WR = 1'b1;
    hpe_host_model_i.tick(1);
    LNK_LEN_WR = 1'b0;
    hpe_host_model_i.idle();
    rd(8'h08, 32'h00000001);
    clr();
    LNK_DATA_WR = 1'b1;
    hpe_host_model_i.tick(1);
    LNK_DATA_WR = 1'b0;
    LNK_LEN_WR = 1'b1;
    hpe_host_model_i.tick(1);
    LNK_LEN_WR = 1'b0;
    hpe_host_model_i.idle();
    rd(8'h08, 32'h00000000);
    GENERIC_MODE = 1'b0;
    $display("test generic done");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60) @(negedge CLK);
    RST_N = 1'b1;
    hpe_host_model_i.idle();
    t_reset();
    t_events();
    t_fifo();
    t_under();
    t_gap();
    t_link();
    t_generic();
    finish_test();
  end
  initial begin
    #200000;
    err_count++;
    finish_test();
  end
endmodule
